// ### msx_pkg.sv
package msx_pkg;

	// operand and memory widths
	localparam int DATA_W = 8;
	localparam int ROM_W = 14;
	localparam int ROM_ADDR_W = 11;
	localparam int REG_ADDR_W = 7;
	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;

	// byte offsets of the register map
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_ACCUM = 12'h008;
	localparam logic [11:0] OFS_TMODE = 12'h00C;
	localparam logic [11:0] OFS_TPTR = 12'h010;
	localparam logic [11:0] OFS_TDATA = 12'h014;
	localparam logic [11:0] OFS_DATA_BASE = 12'h200;

	// command word field positions
	localparam int CMD_IMM_LSB = 0;
	localparam int CMD_REG_LSB = 8;
	localparam int CMD_DEST_BIT = 15;
	localparam int CMD_OP_LSB = 16;
	localparam int CMD_W = 19;

	// status word bit positions
	localparam int STAT_ZERO_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;

	// opcode encodings of the command word
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_SWAP = 3'h1;
	localparam logic [2:0] OP_TMD_LOAD = 3'h2;
	localparam logic [2:0] OP_TMD_READ = 3'h3;
	localparam logic [2:0] OP_TABLE_READ = 3'h4;
	localparam logic [2:0] OP_XOR_REG = 3'h5;
	localparam logic [2:0] OP_XOR_IMM = 3'h6;

	// reset values
	localparam logic [7:0] RST_ACCUM = 8'h00;
	localparam logic [7:0] RST_TMODE = 8'h00;
	localparam logic [7:0] RST_TPTR = 8'h00;
	localparam logic [7:0] RST_TDATA = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one decoded instruction as carried from the command register
	typedef struct packed {
		logic [2:0] op;
		logic dest;
		logic [6:0] reg_addr;
		logic [7:0] imm;
	} msx_cmd_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_FETCH
	} msx_state_type;

endpackage

// ### msx_exec.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module msx_exec
	import msx_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic awvalid,
	output logic awready,
	input wire logic [AXI_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [AXI_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [AXI_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [AXI_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic [ROM_ADDR_W-1:0] rom_addr,
	output logic rom_rd,
	input wire logic [ROM_W-1:0] rom_data,
	output logic [DATA_W-1:0] timer0_mode,
	output logic busy
);

	localparam int DATA_DEPTH = 1 << REG_ADDR_W;

	// architectural state of the datapath
	logic [DATA_W-1:0] accumulator;
	logic [DATA_W-1:0] timer0_mode_reg;
	logic [DATA_W-1:0] table_high_pointer;
	logic [DATA_W-1:0] table_high_data;
	logic zero_flag;
	logic [DATA_W-1:0] data_ram [DATA_DEPTH];

	// bus slave holding registers
	logic aw_hold;
	logic w_hold;
	logic [AXI_ADDR_W-1:0] aw_addr;
	logic [AXI_DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic b_pend;
	logic r_pend;
	logic do_write;

	// sequencer
	msx_state_type state;
	msx_cmd_type cmd;
	msx_cmd_type next_cmd;
	logic cmd_ok;

	// datapath results
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] swap_val;
	logic [DATA_W-1:0] xor_reg_val;
	logic [DATA_W-1:0] xor_imm_val;

	// write and read decode
	logic wr_known;
	logic wr_is_cmd;
	logic [AXI_DATA_W-1:0] rd_word;
	logic [1:0] rd_resp;

	// the freeze input also masks the handshakes so no transfer slips through a frozen edge
	assign awready = ce & ~aw_hold;
	assign wready = ce & ~w_hold;
	assign bvalid = ce & b_pend;
	assign arready = ce & ~r_pend;
	assign rvalid = ce & r_pend;
	assign do_write = ce & aw_hold & w_hold & ~b_pend;
	assign busy = (state != ST_IDLE);
	assign timer0_mode = timer0_mode_reg;

	// operand fetch uses the full seven-bit register field
	assign operand = data_ram[cmd.reg_addr];
	assign swap_val = {operand[3:0], operand[7:4]};
	assign xor_reg_val = accumulator ^ operand;
	assign xor_imm_val = accumulator ^ cmd.imm;

	// command word unpack from the held write data
	always_comb begin
		next_cmd.op = w_data[CMD_OP_LSB +: 3];
		next_cmd.dest = w_data[CMD_DEST_BIT];
		next_cmd.reg_addr = w_data[CMD_REG_LSB +: REG_ADDR_W];
		next_cmd.imm = w_data[CMD_IMM_LSB +: DATA_W];
		cmd_ok = (next_cmd.op != OP_NONE) && (next_cmd.op <= OP_XOR_IMM);
	end

	// write address decode; the data window spans 128 aligned words
	always_comb begin
		wr_is_cmd = (aw_addr[11:2] == OFS_CMD[11:2]);
		wr_known = wr_is_cmd;
		if (aw_addr[11:2] == OFS_STATUS[11:2]) begin
			wr_known = 1'b1;
		end
		if (aw_addr[11:2] == OFS_ACCUM[11:2] || aw_addr[11:2] == OFS_TMODE[11:2]) begin
			wr_known = 1'b1;
		end
		if (aw_addr[11:2] == OFS_TPTR[11:2] || aw_addr[11:2] == OFS_TDATA[11:2]) begin
			wr_known = 1'b1;
		end
		if (aw_addr[11:9] == OFS_DATA_BASE[11:9]) begin
			wr_known = 1'b1;
		end
	end

	// read mux; unmapped words read zero with an error response
	always_comb begin
		rd_word = '0;
		rd_resp = RESP_OKAY;
		if (araddr[11:9] == OFS_DATA_BASE[11:9]) begin
			rd_word[DATA_W-1:0] = data_ram[araddr[8:2]];
		end else if (araddr[11:2] == OFS_CMD[11:2]) begin
			rd_word[CMD_W-1:0] = cmd;
		end else if (araddr[11:2] == OFS_STATUS[11:2]) begin
			rd_word[STAT_ZERO_BIT] = zero_flag;
			rd_word[STAT_BUSY_BIT] = busy;
		end else if (araddr[11:2] == OFS_ACCUM[11:2]) begin
			rd_word[DATA_W-1:0] = accumulator;
		end else if (araddr[11:2] == OFS_TMODE[11:2]) begin
			rd_word[DATA_W-1:0] = timer0_mode_reg;
		end else if (araddr[11:2] == OFS_TPTR[11:2]) begin
			rd_word[DATA_W-1:0] = table_high_pointer;
		end else if (araddr[11:2] == OFS_TDATA[11:2]) begin
			rd_word[DATA_W-1:0] = table_high_data;
		end else begin
			rd_resp = RESP_SLVERR;
		end
	end

	// write address channel: held until the pair is complete
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_hold <= 1'b1;
				aw_addr <= awaddr;
			end else if (do_write) begin
				aw_hold <= 1'b0;
			end
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (ce) begin
			if (wvalid && wready) begin
				w_hold <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (do_write) begin
				w_hold <= 1'b0;
			end
		end
	end

	// write response follows once both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_pend <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				b_pend <= 1'b1;
				bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (b_pend && bready) begin
				b_pend <= 1'b0;
			end
		end
	end

	// read channel: data sampled at the address edge, one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_pend <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				r_pend <= 1'b1;
				rdata <= rd_word;
				rresp <= rd_resp;
			end else if (r_pend && rready) begin
				r_pend <= 1'b0;
			end
		end
	end

	// sequencer: a command write launches one instruction, ignored while busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cmd <= '0;
			rom_addr <= '0;
			rom_rd <= 1'b0;
		end else if (ce) begin
			unique case (state)
				ST_IDLE: begin
					if (do_write && wr_is_cmd && w_strb[2] && cmd_ok) begin
						cmd <= next_cmd;
						state <= ST_EXEC;
						if (next_cmd.op == OP_TABLE_READ) begin
							rom_addr <= {table_high_pointer[2:0], accumulator};
							rom_rd <= 1'b1;
						end
					end
				end
				ST_EXEC: begin
					rom_rd <= 1'b0;
					// table read needs a second cycle for the program word to return
					state <= (cmd.op == OP_TABLE_READ) ? ST_FETCH : ST_IDLE;
				end
				ST_FETCH: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// datapath registers; execution owns them, software writes only when idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			accumulator <= RST_ACCUM;
			timer0_mode_reg <= RST_TMODE;
			table_high_pointer <= RST_TPTR;
			table_high_data <= RST_TDATA;
			zero_flag <= 1'b0;
			for (int i = 0; i < DATA_DEPTH; i++) begin
				data_ram[i] <= RST_DATA;
			end
		end else if (ce) begin
			if (state == ST_EXEC) begin
				// flags stay put except for the two xor forms
				unique case (cmd.op)
					OP_SWAP: begin
						if (cmd.dest) begin
							data_ram[cmd.reg_addr] <= swap_val;
						end else begin
							accumulator <= swap_val;
						end
					end
					OP_TMD_LOAD: begin
						timer0_mode_reg <= accumulator;
					end
					OP_TMD_READ: begin
						accumulator <= timer0_mode_reg;
					end
					OP_XOR_REG: begin
						if (cmd.dest) begin
							data_ram[cmd.reg_addr] <= xor_reg_val;
						end else begin
							accumulator <= xor_reg_val;
						end
						zero_flag <= (xor_reg_val == 8'h00);
					end
					OP_XOR_IMM: begin
						accumulator <= xor_imm_val;
						zero_flag <= (xor_imm_val == 8'h00);
					end
					default: begin
						// table read does its work in the fetch cycle
					end
				endcase
			end else if (state == ST_FETCH) begin
				accumulator <= rom_data[7:0];
				table_high_data[5:0] <= rom_data[13:8];
			end else if (do_write && w_strb[0]) begin
				// direct loads let software set up operands before a launch
				if (aw_addr[11:9] == OFS_DATA_BASE[11:9]) begin
					data_ram[aw_addr[8:2]] <= w_data[7:0];
				end else if (aw_addr[11:2] == OFS_ACCUM[11:2]) begin
					accumulator <= w_data[7:0];
				end else if (aw_addr[11:2] == OFS_TMODE[11:2]) begin
					timer0_mode_reg <= w_data[7:0];
				end else if (aw_addr[11:2] == OFS_TPTR[11:2]) begin
					table_high_pointer <= w_data[7:0];
				end else if (aw_addr[11:2] == OFS_TDATA[11:2]) begin
					table_high_data <= w_data[7:0];
				end
			end
		end
	end

endmodule // msx_exec

// ### msx_exec_assertions.sv
`timescale 1ns/1ps
module msx_exec_checker
	import msx_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic rom_rd,
	input wire logic [ROM_ADDR_W-1:0] rom_addr,
	input wire logic busy,
	input wire logic [DATA_W-1:0] timer0_mode
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// the fetch strobe lasts one cycle, inside the busy window
	rom_pulse_a: assert property (rom_rd |=> !rom_rd && busy)
		else $error("fetch strobe longer than one cycle");
	rom_busy_a: assert property (rom_rd |-> busy)
		else $error("fetch strobe outside a busy cycle");
	// table read takes exactly two cycles, then the core is free
	fetch_len_a: assert property (rom_rd |=> ##1 !busy)
		else $error("table read not two cycles");
	// the word arrives a cycle late, so the address must not move meanwhile
	addr_hold_a: assert property (rom_rd |=> $stable(rom_addr))
		else $error("program address moved during fetch");
	// only the table read may occupy a second busy cycle
	busy_two_a: assert property (busy ##1 busy |-> $past(rom_rd))
		else $error("single cycle instruction held busy");
	busy_max_a: assert property (busy ##1 busy |=> !busy)
		else $error("busy longer than two cycles");
	mode_keep_a: assert property (rom_rd |=> ##1 timer0_mode == $past(timer0_mode, 2))
		else $error("timer mode changed by table read");
	read_ans_a: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	// a read and a write may complete side by side, so each channel is checked alone
	read_done_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read data held after handshake");
	write_done_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response held after handshake");
endmodule // msx_exec_checker

bind msx_exec msx_exec_checker i_msx_exec_checker (
	.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .bvalid(bvalid), .bready(bready),
	.rom_rd(rom_rd), .rom_addr(rom_addr), .busy(busy), .timer0_mode(timer0_mode)
);

// ### msx_rom_model.sv
`timescale 1ns/1ps
module msx_rom_model
	import msx_pkg::*;
(
	input wire logic aclk,
	input wire logic rom_rd,
	input wire logic [ROM_ADDR_W-1:0] rom_addr,
	output logic [ROM_W-1:0] rom_data
);
	logic [ROM_W-1:0] mem [2048];

	// program words filled with a scrambled pattern so every bit gets exercised
	initial begin
		for (int i = 0; i < 2048; i++) mem[i] = ROM_W'(i * 37 ^ 14'h2A5C);
	end

	// word valid only in the cycle after the strobe; otherwise bits toggle
	always @(posedge aclk) rom_data <= rom_rd ? mem[rom_addr] : ~rom_data;
endmodule // msx_rom_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top import msx_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, dest, z = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rd;
	logic [2:0] awprot = 3'h0, op;
	logic [1:0] rs, bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, rom_rd, busy;
	logic [31:0] rdata;
	logic [10:0] rom_addr;
	logic [13:0] rom_data, w;
	logic [7:0] timer0_mode, accu = 8'h00, t0 = 8'h00, tptr, tdat = 8'h00, x, imm, regs [128];
	logic [3:0] strb = 4'hF;
	logic [31:0] lc = 32'h0;
	logic [6:0] r;
	int fails = 0, comparisons = 0, seed = 32'h50c0eb69, n;

	always #50 aclk = ~aclk;

	// responses are always accepted; clock enable stays on
	msx_exec i_msx_exec (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(strb), .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(1'b1), .rdata(rdata), .rresp(rresp), .rom_addr(rom_addr), .rom_rd(rom_rd),
		.rom_data(rom_data), .timer0_mode(timer0_mode), .busy(busy));
	msx_rom_model i_msx_rom_model (.aclk(aclk), .rom_rd(rom_rd), .rom_addr(rom_addr),
		.rom_data(rom_data));

	task automatic give_verdict;
		if (fails == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a wait that ran out counts as a mismatch and ends the run
	task automatic limit(input int k);
		if (k >= 20) begin
			fails++;
			$display("wrong value at %0t: no answer", $time);
			give_verdict;
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		int k;
		awaddr <= a;
		wdata <= d;
		awprot <= 3'($random(seed));
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		limit(k);
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		resp = rresp;
		limit(k);
	endtask

	// upper bits are random: only the low byte may land in a register
	task automatic reg_w(input logic [11:0] a, input logic [7:0] v);
		axw(a, $random(seed) & 32'hFFFFFF00 | v, rs);
		chk({rs, 32'h0}, {RESP_OKAY, 32'h0});
	endtask

	task automatic reg_c(input logic [11:0] a, input logic [7:0] e);
		axr(a, rd, rs);
		chk({rs, rd}, {RESP_OKAY, 24'h0, e});
	endtask

	initial begin
		for (int i = 0; i < 128; i++) regs[i] = RST_DATA;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reg_c(OFS_ACCUM, RST_ACCUM);
		reg_c(OFS_TDATA, RST_TDATA);
		reg_c(OFS_TPTR, RST_TPTR);
		reg_c(OFS_TMODE, RST_TMODE);
		axr(OFS_CMD, rd, rs);
		chk({rs, rd}, {RESP_OKAY, 32'h0});
		axr(12'h100, rd, rs);
		chk({rs, rd}, {RESP_SLVERR, 32'h0});
		axw(12'h100, 32'h000000FF, rs);
		chk({rs, 32'h0}, {RESP_SLVERR, 32'h0});
		for (int k = 0; k < 60; k++) begin
			accu = 8'($random(seed));
			tptr = 8'($random(seed));
			tdat = 8'($random(seed));
			{op, dest, r} = 11'($random(seed));
			// every fourth pass forces a zero xor result
			imm = (k % 4 == 0) ? accu : 8'($random(seed));
			regs[r] = (k % 4 == 0) ? accu : 8'($random(seed));
			reg_w(OFS_ACCUM, accu);
			reg_w(OFS_TPTR, tptr);
			reg_w(OFS_TDATA, tdat);
			reg_w(OFS_DATA_BASE + {3'h0, r, 2'h0}, regs[r]);
			axw(OFS_CMD, {13'h0, op, dest, r, imm}, rs);
			chk({rs, 32'h0}, {RESP_OKAY, 32'h0});
			// opcodes 0 and 7 launch nothing, so the readback keeps the last command
			if (op != OP_NONE && op != 3'h7) lc = {13'h0, op, dest, r, imm};
			for (n = 0; n < 20; n++) begin
				@(posedge aclk);
				if (busy === 1'b0) break;
			end
			limit(n);
			// reference result of the launched instruction
			case (op)
				OP_SWAP: begin
					x = {regs[r][3:0], regs[r][7:4]};
					if (dest) regs[r] = x;
					else accu = x;
				end
				OP_TMD_LOAD: t0 = accu;
				OP_TMD_READ: accu = t0;
				OP_TABLE_READ: begin
					w = i_msx_rom_model.mem[{tptr[2:0], accu}];
					accu = w[7:0];
					tdat[5:0] = w[13:8];
				end
				OP_XOR_REG, OP_XOR_IMM: begin
					x = accu ^ (op == OP_XOR_IMM ? imm : regs[r]);
					z = (x == 8'h00);
					if (dest && op == OP_XOR_REG) regs[r] = x;
					else accu = x;
				end
				default: ;
			endcase
			reg_c(OFS_ACCUM, accu);
			reg_c(OFS_TMODE, t0);
			reg_c(OFS_TDATA, tdat);
			reg_c(OFS_TPTR, tptr);
			reg_c(OFS_STATUS, {7'h0, z});
			reg_c(OFS_DATA_BASE + {3'h0, r, 2'h0}, regs[r]);
			axr(OFS_CMD, rd, rs);
			chk({rs, rd}, {RESP_OKAY, lc});
			chk({26'h0, timer0_mode}, {26'h0, t0});
		end
		// a missing byte-0 strobe blocks a load, a missing byte-2 strobe blocks a launch
		strb <= 4'hE;
		axw(OFS_ACCUM, {24'h0, ~accu}, rs);
		chk({rs, 32'h0}, {RESP_OKAY, 32'h0});
		strb <= 4'hB;
		axw(OFS_CMD, {13'h0, OP_XOR_IMM, 8'h00, 8'hFF}, rs);
		chk({rs, 32'h0}, {RESP_OKAY, 32'h0});
		strb <= 4'hF;
		reg_c(OFS_STATUS, {7'h0, z});
		reg_c(OFS_ACCUM, accu);
		// a reset in mid-run must clear what the instructions left behind
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reg_c(OFS_ACCUM, RST_ACCUM);
		reg_c(OFS_STATUS, 8'h00);
		reg_c(OFS_DATA_BASE + {3'h0, r, 2'h0}, RST_DATA);
		chk({26'h0, timer0_mode}, {26'h0, RST_TMODE});
		give_verdict;
	end
endmodule // tb_top
